/* hw/standby_pkg.sv */
// Shared constants and types for the standby power-down controller.
package standby_pkg;
    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Control register field positions.
    localparam int STANDBY_SELECT_BIT = 0;
    localparam int LOW_SPEED_ON_BIT = 1;
    localparam int MEDIUM_SPEED_ON_BIT = 2;
    localparam int TIMER_SEL_LSB = 4;
    localparam int TIMER_SEL_W = 3;
    localparam int EXT_INT_ZERO_EN_BIT = 8;
    localparam int EXT_INT_ONE_EN_BIT = 9;
    localparam int WAKE_EN_LSB = 16;
    localparam int WAKE_W = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status register field positions.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_MEDIUM_BIT = 2;
    localparam int STAT_CPG_BIT = 3;

    // Clock tap chain lengths: system /2../8192, watch /2../128.
    localparam int SYS_DIV_STAGES = 13;
    localparam int WATCH_DIV_STAGES = 7;

    // Stabilisation time unit, scaled by two to the standby timer code.
    localparam int CLK_PERIOD_NS = 25;
    localparam int STAB_UNIT_NS = 6400;
    localparam int STAB_UNIT_CYCLES = (STAB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_W = 24;

    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_STANDBY,
        MODE_STABILISE,
        MODE_RESET_HOLD
    } power_mode_t;
endpackage : standby_pkg

/* hw/clock_tap_divider.sv */
// Binary ripple-free divider chain that offers every power-of-two tap of its source.
`timescale 1ns/1ps
module clock_tap_divider #(
    parameter int STAGES = 13
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic advance_i,
    output logic [STAGES-1:0] taps_o
);
    logic [STAGES-1:0] count_reg;

    // Bit k toggles every 2**k advances, so it is the source divided by 2**(k+1).
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            count_reg <= '0;
        else if (advance_i)
            count_reg <= count_reg + {{(STAGES-1){1'b0}}, 1'b1};
    end

    assign taps_o = count_reg;
endmodule : clock_tap_divider

/* hw/standby_power_down_control.sv */
// Standby power-down sequencer with Avalon-MM control and status registers.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module standby_power_down_control #(
    parameter bit FLASH_VARIANT = 1'b1,
    parameter int STAB_UNIT_CYCLES = standby_pkg::STAB_UNIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [standby_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sleep_exec_i,
    input wire logic timer_a_clock_source_bit_i,
    input wire logic int_mask_i,
    input wire logic external_interrupt_zero_i,
    input wire logic external_interrupt_one_i,
    input wire logic [standby_pkg::WAKE_W-1:0] wakeup_inputs_i,
    input wire logic reset_pin_low_i,
    input wire logic watch_tick_i,
    output logic cpg_run_o,
    output logic cpu_run_o,
    output logic retain_o,
    output logic port_hiz_o,
    output logic port5_hold_o,
    output logic medium_speed_active_o,
    output logic int_handle_o,
    output logic reset_handle_o,
    output logic [standby_pkg::SYS_DIV_STAGES-1:0] sys_taps_o,
    output logic [standby_pkg::WATCH_DIV_STAGES-1:0] watch_taps_o
);
    standby_pkg::power_mode_t mode_reg;
    logic [31:0] ctrl_reg;
    logic [standby_pkg::STAB_W-1:0] stab_count_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic cpg_reg;
    logic cpu_reg;
    logic medium_reg;
    logic int_pulse_reg;
    logic rst_pulse_reg;
    logic enter_ok;
    logic wake_req;
    logic bus_req;
    logic [standby_pkg::TIMER_SEL_W-1:0] timer_sel;

    assign bus_req = avs_read_i | avs_write_i;
    assign timer_sel = ctrl_reg[standby_pkg::TIMER_SEL_LSB +: standby_pkg::TIMER_SEL_W];

    // Entry needs all three select conditions together with the sleep instruction.
    assign enter_ok = sleep_exec_i && ctrl_reg[standby_pkg::STANDBY_SELECT_BIT]
        && !ctrl_reg[standby_pkg::LOW_SPEED_ON_BIT] && !timer_a_clock_source_bit_i;

    // A wake source counts only when enabled and not masked by the CPU.
    assign wake_req = !int_mask_i && (
        (external_interrupt_zero_i && ctrl_reg[standby_pkg::EXT_INT_ZERO_EN_BIT])
        || (external_interrupt_one_i && ctrl_reg[standby_pkg::EXT_INT_ONE_EN_BIT])
        || |(wakeup_inputs_i & ctrl_reg[standby_pkg::WAKE_EN_LSB +: standby_pkg::WAKE_W]));

    // Bus handshake: each request waits one cycle, then is answered for exactly one edge.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            wait_reg <= 1'b1;
        else
            wait_reg <= !(bus_req && wait_reg);
    end

    // Read data is captured in the wait cycle so it stands at the answering edge.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            rdata_reg <= 32'h0000_0000;
        else if (avs_read_i && wait_reg)
        begin
            unique case (avs_address_i)
                standby_pkg::CTRL_OFFSET: rdata_reg <= ctrl_reg;
                standby_pkg::STATUS_OFFSET: rdata_reg <= {28'h0000000, cpg_reg, medium_reg, mode_reg};
                default: rdata_reg <= 32'h0000_0000; // Unmapped reads return zero.
            endcase
        end
    end

    // Control register, cleared by the reset pin as the whole chip restarts.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !reset_pin_low_i)
            ctrl_reg <= standby_pkg::CTRL_RESET;
        else if (avs_write_i && !wait_reg && avs_address_i == standby_pkg::CTRL_OFFSET)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (avs_byteenable_i[b])
                    ctrl_reg[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            end
        end
    end

    // Power mode sequencer; the reset pin overrides every other transition.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mode_reg <= standby_pkg::MODE_ACTIVE;
            stab_count_reg <= '0;
            int_pulse_reg <= 1'b0;
            rst_pulse_reg <= 1'b0;
            medium_reg <= 1'b0;
        end
        else
        begin
            int_pulse_reg <= 1'b0;
            rst_pulse_reg <= 1'b0;
            if (!reset_pin_low_i)
                mode_reg <= standby_pkg::MODE_RESET_HOLD;
            else
            begin
                unique case (mode_reg)
                    standby_pkg::MODE_ACTIVE:
                        if (enter_ok)
                            mode_reg <= standby_pkg::MODE_STANDBY;
                    standby_pkg::MODE_STANDBY:
                        if (wake_req)
                        begin
                            mode_reg <= standby_pkg::MODE_STABILISE;
                            stab_count_reg <= standby_pkg::STAB_W'(STAB_UNIT_CYCLES) << timer_sel;
                        end
                    standby_pkg::MODE_STABILISE:
                        if (stab_count_reg == '0)
                        begin
                            mode_reg <= standby_pkg::MODE_ACTIVE;
                            int_pulse_reg <= 1'b1;
                            medium_reg <= ctrl_reg[standby_pkg::MEDIUM_SPEED_ON_BIT];
                        end
                        else
                            stab_count_reg <= stab_count_reg - standby_pkg::STAB_W'(1);
                    standby_pkg::MODE_RESET_HOLD:
                    begin
                        // Reset handling starts once the pin is released.
                        mode_reg <= standby_pkg::MODE_ACTIVE;
                        rst_pulse_reg <= 1'b1;
                        medium_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Clock gates follow the next mode so they switch together with the sequencer.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cpg_reg <= 1'b1;
            cpu_reg <= 1'b1;
        end
        else if (!reset_pin_low_i)
        begin
            cpg_reg <= 1'b1;
            cpu_reg <= 1'b0;
        end
        else if (mode_reg == standby_pkg::MODE_ACTIVE && enter_ok)
        begin
            cpg_reg <= 1'b0;
            cpu_reg <= 1'b0;
        end
        else if (mode_reg == standby_pkg::MODE_STANDBY && wake_req)
            cpg_reg <= 1'b1;
        else if (mode_reg == standby_pkg::MODE_STABILISE && stab_count_reg == '0)
            cpu_reg <= 1'b1;
        else if (mode_reg == standby_pkg::MODE_RESET_HOLD)
            cpu_reg <= 1'b1;
    end

    // System taps only advance while the CPU clock runs; the watch chain follows the subclock tick.
    clock_tap_divider #(
        .STAGES(standby_pkg::SYS_DIV_STAGES)
    ) sys_div_u (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .advance_i(cpu_reg),
        .taps_o(sys_taps_o)
    );

    clock_tap_divider #(
        .STAGES(standby_pkg::WATCH_DIV_STAGES)
    ) watch_div_u (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .advance_i(watch_tick_i),
        .taps_o(watch_taps_o)
    );

    // Retention and pin float decode the next mode being standby, registered so outputs are glitch free.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            retain_o <= 1'b0;
            port_hiz_o <= 1'b0;
            port5_hold_o <= 1'b0;
        end
        else
        begin
            retain_o <= (mode_reg == standby_pkg::MODE_ACTIVE && enter_ok && reset_pin_low_i)
                || (mode_reg == standby_pkg::MODE_STANDBY && !wake_req && reset_pin_low_i);
            port_hiz_o <= (mode_reg == standby_pkg::MODE_ACTIVE && enter_ok && reset_pin_low_i)
                || (mode_reg == standby_pkg::MODE_STANDBY && !wake_req && reset_pin_low_i);
            port5_hold_o <= FLASH_VARIANT && ((mode_reg == standby_pkg::MODE_ACTIVE && enter_ok && reset_pin_low_i)
                || (mode_reg == standby_pkg::MODE_STANDBY && !wake_req && reset_pin_low_i));
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o = rdata_reg;
    assign cpg_run_o = cpg_reg;
    assign cpu_run_o = cpu_reg;
    assign medium_speed_active_o = medium_reg;
    assign int_handle_o = int_pulse_reg;
    assign reset_handle_o = rst_pulse_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    entry_cond_a: assert property ((mode_reg == standby_pkg::MODE_ACTIVE && enter_ok && reset_pin_low_i)
        |=> mode_reg == standby_pkg::MODE_STANDBY && port_hiz_o) else $error("standby not entered");
    no_entry_a: assert property ((mode_reg == standby_pkg::MODE_ACTIVE && sleep_exec_i && !enter_ok
        && reset_pin_low_i) |=> mode_reg == standby_pkg::MODE_ACTIVE) else $error("standby entered wrongly");
    clock_stop_a: assert property (mode_reg == standby_pkg::MODE_STANDBY
        |-> !cpg_run_o && !cpu_run_o) else $error("clock runs in standby");
    retain_hold_a: assert property ((mode_reg == standby_pkg::MODE_STANDBY && $past(mode_reg) ==
        standby_pkg::MODE_STANDBY) |-> retain_o) else $error("retention dropped in standby");
    port_float_a: assert property ($rose(mode_reg == standby_pkg::MODE_STANDBY)
        |-> port_hiz_o && port5_hold_o == FLASH_VARIANT) else $error("ports not floated");
    port5_keep_a: assert property (port_hiz_o |-> port5_hold_o == FLASH_VARIANT) else $error("port 5 wrong");
    tap_freeze_a: assert property (!cpu_run_o |=> $stable(sys_taps_o)) else $error("taps run while halted");
    wake_go_a: assert property ((mode_reg == standby_pkg::MODE_STANDBY && wake_req && reset_pin_low_i)
        |=> mode_reg == standby_pkg::MODE_STABILISE && cpg_run_o && !cpu_run_o) else $error("wake missed");
    stab_end_a: assert property ((mode_reg == standby_pkg::MODE_STABILISE && stab_count_reg == '0
        && reset_pin_low_i) |=> int_handle_o && cpu_run_o
        && medium_speed_active_o == $past(ctrl_reg[standby_pkg::MEDIUM_SPEED_ON_BIT]))
        else $error("resume after stabilisation wrong");
    masked_stay_a: assert property ((mode_reg == standby_pkg::MODE_STANDBY && int_mask_i && reset_pin_low_i)
        |=> mode_reg == standby_pkg::MODE_STANDBY) else $error("masked interrupt woke device");
    reset_wake_a: assert property (!reset_pin_low_i |=> cpg_run_o && !cpu_run_o
        && mode_reg == standby_pkg::MODE_RESET_HOLD) else $error("reset pin did not restart clock");

    standby_enter_c: cover property (mode_reg == standby_pkg::MODE_ACTIVE ##1 mode_reg == standby_pkg::MODE_STANDBY);
    int_wake_c: cover property (mode_reg == standby_pkg::MODE_STABILISE ##1 int_handle_o);
    reset_wake_c: cover property (mode_reg == standby_pkg::MODE_STANDBY ##1 mode_reg == standby_pkg::MODE_RESET_HOLD);
endmodule : standby_power_down_control

/* sim/cpu_side_model.sv */
// Behavioural CPU, watch clock and reset pin facing the standby controller.
`timescale 1ns/1ps
module cpu_side_model #(
    parameter int HOLD_CYCLES = 8
) (
    input wire logic clk_i,
    input wire logic sleep_req_i,
    input wire logic reset_req_i,
    output logic sleep_exec_o = 1'b0,
    output logic reset_pin_low_o,
    output logic watch_tick_o
);
    int hold_cnt = 0;
    logic [1:0] tick_cnt = 2'h0;
    // The sleep instruction retires one cycle after the bench asks for it.
    always @(posedge clk_i)
    begin
        sleep_exec_o <= sleep_req_i;
    end
    // The pin stays low until the restarted generator has settled.
    always @(posedge clk_i)
    begin
        if (reset_req_i)
            hold_cnt <= HOLD_CYCLES;
        else if (hold_cnt > 0)
            hold_cnt <= hold_cnt - 1;
    end
    assign reset_pin_low_o = (hold_cnt == 0);
    // The subclock runs free, so the watch tick never stops.
    always @(posedge clk_i)
    begin
        tick_cnt <= tick_cnt + 2'h1;
    end
    assign watch_tick_o = (tick_cnt == 2'h3);
endmodule : cpu_side_model

/* sim/standby_power_down_control_bench.sv */
// Self-checking bench for the standby power-down controller.
`timescale 1ns/1ps
module standby_power_down_control_bench;
    localparam int UNIT = 2;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic sleep_req = 1'b0;
    logic reset_req = 1'b0;
    logic tmr_a = 1'b0;
    logic mask = 1'b0;
    logic ext_zero = 1'b0;
    logic ext_one = 1'b0;
    logic [7:0] wake = 8'h00;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_o, sleep_exec, pin_low, tick, cpg, cpu, retain, hiz, p5, med, int_h, rst_handle;
    logic [12:0] sys_taps;
    logic [6:0] watch_taps;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    standby_power_down_control #(.FLASH_VARIANT(1'b1), .STAB_UNIT_CYCLES(UNIT)) u_standby_power_down_control (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_byteenable_i(be), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .sleep_exec_i(sleep_exec), .timer_a_clock_source_bit_i(tmr_a), .int_mask_i(mask),
        .external_interrupt_zero_i(ext_zero), .external_interrupt_one_i(ext_one), .wakeup_inputs_i(wake),
        .reset_pin_low_i(pin_low), .watch_tick_i(tick), .cpg_run_o(cpg), .cpu_run_o(cpu), .retain_o(retain),
        .port_hiz_o(hiz), .port5_hold_o(p5), .medium_speed_active_o(med), .int_handle_o(int_h),
        .reset_handle_o(rst_handle), .sys_taps_o(sys_taps), .watch_taps_o(watch_taps));
    cpu_side_model #(.HOLD_CYCLES(8)) u_cpu_side_model (.clk_i(clk_i), .sleep_req_i(sleep_req),
        .reset_req_i(reset_req), .sleep_exec_o(sleep_exec), .reset_pin_low_o(pin_low), .watch_tick_o(tick));
    // Free-running clock at 40 MHz.
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // A hang anywhere ends the run as a failure instead of spinning forever.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    // One Avalon access; the request is held until waitrequest is seen low.
    task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        rd <= !is_wr;
        wr <= is_wr;
        // Waitrequest is judged at the rising edge, where it and the read data still hold their launched values.
        @(posedge clk_i);
        while (wait_o !== 1'b0)
            @(posedge clk_i);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic go_sleep(input logic [31:0] ctrl);
        logic [31:0] q;
        bus(1'b1, standby_pkg::CTRL_OFFSET, ctrl, q);
        @(posedge clk_i);
        sleep_req <= 1'b1;
        @(posedge clk_i);
        sleep_req <= 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : go_sleep
    // Waits up to a bound for a pulse and returns how many cycles it took.
    task automatic wait_pulse(input int which, output int n);
        n = 0;
        while (((which == 0) ? int_h : rst_handle) !== 1'b1 && n < 40)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_pulse
    task automatic t_regs();
        logic [31:0] q;
        logic [12:0] s;
        bus(1'b0, standby_pkg::CTRL_OFFSET, 32'h0, q);
        check_val("ctrl reset", standby_pkg::CTRL_RESET, q);
        bus(1'b1, standby_pkg::CTRL_OFFSET, 32'h00FF_0377, q);
        bus(1'b0, standby_pkg::CTRL_OFFSET, 32'h0, q);
        check_val("ctrl readback", 32'h00FF_0377, q);
        // Only the lowest byte lane may change under a partial write.
        @(posedge clk_i);
        be <= 4'h1;
        bus(1'b1, standby_pkg::CTRL_OFFSET, 32'hFFFF_FFFF, q);
        be <= 4'hF;
        bus(1'b0, standby_pkg::CTRL_OFFSET, 32'h0, q);
        check_val("ctrl byte lane", 32'h00FF_03FF, q);
        bus(1'b1, standby_pkg::STATUS_OFFSET, 32'hFFFF_FFFF, q);
        bus(1'b0, standby_pkg::STATUS_OFFSET, 32'h0, q);
        check_val("status active", 32'h0000_0008, q);
        bus(1'b0, 4'h8, 32'h0, q);
        check_val("unmapped", 32'h0, q);
        // A running system chain counts once per cycle, so bit k divides by two to the k plus one.
        @(negedge clk_i);
        s = sys_taps;
        repeat (8) @(negedge clk_i);
        check_val("sys taps rate", {19'h0, s + 13'h0008}, {19'h0, sys_taps});
    endtask : t_regs
    // Each missing entry condition must leave the clocks running.
    task automatic t_refuse();
        logic [31:0] ctrl [3] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0001};
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i);
            tmr_a <= (i == 2);
            go_sleep(ctrl[i]);
            check_val("refused cpg", 32'h1, {31'h0, cpg});
            check_val("refused retain", 32'h0, {31'h0, retain});
        end
        @(posedge clk_i);
        tmr_a <= 1'b0;
    endtask : t_refuse
    task automatic t_irq_wake();
        logic [12:0] s;
        logic [6:0] w;
        int n;
        go_sleep(32'h0000_0115);
        check_val("standby cpg", 32'h0, {31'h0, cpg});
        check_val("standby cpu", 32'h0, {31'h0, cpu});
        check_val("standby retain", 32'h1, {31'h0, retain});
        check_val("standby hiz", 32'h1, {31'h0, hiz});
        check_val("standby port5", 32'h1, {31'h0, p5});
        s = sys_taps;
        w = watch_taps;
        repeat (16) @(negedge clk_i);
        check_val("sys taps frozen", {19'h0, s}, {19'h0, sys_taps});
        check_val("watch taps rate", {25'h0, w + 7'h04}, {25'h0, watch_taps});
        @(posedge clk_i);
        mask <= 1'b1;
        ext_zero <= 1'b1;
        repeat (8) @(negedge clk_i);
        check_val("masked irq", 32'h0, {31'h0, cpg});
        @(posedge clk_i);
        ext_zero <= 1'b0;
        ext_one <= 1'b1;
        mask <= 1'b0;
        repeat (8) @(negedge clk_i);
        check_val("disabled irq", 32'h0, {31'h0, cpg});
        @(posedge clk_i);
        ext_one <= 1'b0;
        ext_zero <= 1'b1;
        n = 0;
        while (cpg !== 1'b1 && n < 10)
        begin
            @(negedge clk_i);
            n++;
        end
        check_val("restart hiz", 32'h0, {31'h0, hiz});
        wait_pulse(0, n);
        check_val("stabilise cycles", UNIT * 2 + 1, n);
        check_val("resume cpu", 32'h1, {31'h0, cpu});
        check_val("resume medium", 32'h1, {31'h0, med});
        @(posedge clk_i);
        ext_zero <= 1'b0;
    endtask : t_irq_wake
    task automatic t_pin_wake();
        int n;
        go_sleep(32'h0020_0001);
        @(posedge clk_i);
        wake <= 8'h04;
        repeat (8) @(negedge clk_i);
        check_val("disabled wake pin", 32'h0, {31'h0, cpg});
        @(posedge clk_i);
        wake <= 8'h24;
        // Counting starts half a cycle before the edge that sees the enabled pin.
        @(negedge clk_i);
        wait_pulse(0, n);
        check_val("wake pin cycles", UNIT + 2, n);
        check_val("resume high speed", 32'h0, {31'h0, med});
        @(posedge clk_i);
        wake <= 8'h00;
    endtask : t_pin_wake
    task automatic t_reset_pin();
        logic [31:0] q;
        int n;
        go_sleep(32'h0000_0001);
        @(posedge clk_i);
        reset_req <= 1'b1;
        @(posedge clk_i);
        reset_req <= 1'b0;
        repeat (4) @(negedge clk_i);
        check_val("reset hold cpg", 32'h1, {31'h0, cpg});
        check_val("reset hold cpu", 32'h0, {31'h0, cpu});
        wait_pulse(1, n);
        check_val("reset handled", 32'h1, {31'h0, rst_handle});
        @(negedge clk_i);
        check_val("reset cpu", 32'h1, {31'h0, cpu});
        bus(1'b0, standby_pkg::CTRL_OFFSET, 32'h0, q);
        check_val("ctrl after pin", 32'h0, q);
    endtask : t_reset_pin
    // Reset, then the scenarios in turn.
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_refuse();
        t_irq_wake();
        t_pin_wake();
        t_reset_pin();
        close_out();
    end
endmodule : standby_power_down_control_bench
